// ===== include/fsp_pkg.sv
package fsp_pkg;

	// geometry of the documented part
	localparam int FSP_ADDR_W = 17;
	localparam int FSP_LANES = 4;
	localparam int FSP_LANE_W = 8;
	localparam int FSP_DATA_W = FSP_LANES * FSP_LANE_W;
	localparam int FSP_BURST_W = 2;
	localparam int FSP_BURST_LEN = 4;

	// values after reset
	localparam logic [FSP_BURST_W-1:0] FSP_CNT_RESET = 2'h0;
	localparam logic [FSP_BURST_W-1:0] FSP_LOW_RESET = 2'h0;
	localparam logic [FSP_ADDR_W-1:0] FSP_ADDR_RESET = 17'h00000;
	localparam logic [FSP_DATA_W-1:0] FSP_DATA_RESET = 32'h00000000;
	localparam logic [FSP_LANES-1:0] FSP_PAR_RESET = 4'h0;
	localparam logic [FSP_LANES-1:0] FSP_LANES_OFF = 4'hF;

	// access state of the port; idle is the deselected state
	typedef enum logic [2:0] {
		FSP_ST_IDLE = 3'h1,
		FSP_ST_READ = 3'h2,
		FSP_ST_WRITE = 3'h4
	} fsp_state_type;

	// low two address bits of beat cnt of a burst
	function automatic logic [FSP_BURST_W-1:0] fsp_burst_low(
		input logic [FSP_BURST_W-1:0] start,
		input logic [FSP_BURST_W-1:0] cnt,
		input logic interleave
	);
		fsp_burst_low = interleave ? (start ^ cnt) : FSP_BURST_W'(start + cnt);
	endfunction

	// replace only the byte lanes whose active-low select is asserted
	function automatic logic [FSP_DATA_W-1:0] fsp_merge_data(
		input logic [FSP_DATA_W-1:0] old_word,
		input logic [FSP_DATA_W-1:0] new_word,
		input logic [FSP_LANES-1:0] lane_n
	);
		fsp_merge_data = old_word;
		for (int i = 0; i < FSP_LANES; i++) begin
			if (!lane_n[i]) begin
				fsp_merge_data[i*FSP_LANE_W +: FSP_LANE_W] = new_word[i*FSP_LANE_W +: FSP_LANE_W];
			end
		end
	endfunction

	// parity bit n follows byte lane n
	function automatic logic [FSP_LANES-1:0] fsp_merge_par(
		input logic [FSP_LANES-1:0] old_par,
		input logic [FSP_LANES-1:0] new_par,
		input logic [FSP_LANES-1:0] lane_n
	);
		fsp_merge_par = (old_par & lane_n) | (new_par & ~lane_n);
	endfunction

endpackage

// ===== include/fsp_mem_if.sv
interface fsp_mem_if #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 32,
	parameter int LANES = 4
);
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic [LANES-1:0] rd_par;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [LANES-1:0] wr_par;
	logic [LANES-1:0] wr_lane_n;

	modport ctl (
		output rd_addr,
		input rd_data,
		input rd_par,
		output wr_en,
		output wr_addr,
		output wr_data,
		output wr_par,
		output wr_lane_n
	);

	modport core (
		input rd_addr,
		output rd_data,
		output rd_par,
		input wr_en,
		input wr_addr,
		input wr_data,
		input wr_par,
		input wr_lane_n
	);
endinterface

// ===== rtl/fsp_core.sv
module fsp_core
	import fsp_pkg::*;
#(
	parameter int ADDR_W = FSP_ADDR_W,
	parameter int DATA_W = FSP_DATA_W,
	parameter int LANES = FSP_LANES
) (
	input wire logic mclk,
	fsp_mem_if.core mem
);

	// contents are not cleared by reset, as in the real array
	logic [DATA_W-1:0] data_mem [2**ADDR_W];
	logic [LANES-1:0] par_mem [2**ADDR_W];

	// flow-through: the read port is combinational
	assign mem.rd_data = data_mem[mem.rd_addr];
	assign mem.rd_par = par_mem[mem.rd_addr];

	always_ff @(posedge mclk) begin
		if (mem.wr_en) begin
			data_mem[mem.wr_addr] <= fsp_merge_data(data_mem[mem.wr_addr], mem.wr_data,
				mem.wr_lane_n);
			par_mem[mem.wr_addr] <= fsp_merge_par(par_mem[mem.wr_addr], mem.wr_par,
				mem.wr_lane_n);
		end
	end

endmodule

// ===== rtl/fsp_port.sv
module fsp_port
	import fsp_pkg::*;
#(
	parameter int ADDR_W = FSP_ADDR_W,
	parameter int DATA_W = FSP_DATA_W,
	parameter int LANES = FSP_LANES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clock_qualify_n,
	input wire logic chip_select_low_a,
	input wire logic chip_select_high_b,
	input wire logic chip_select_low_c,
	input wire logic advance_or_load,
	input wire logic write_enable_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic output_enable_n,
	input wire logic burst_order,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES-1:0] parity_out,
	output logic parity_oe
);

	// ------------------------------------------------------------------
	// decode of the current edge
	// ------------------------------------------------------------------

	logic suspend;
	logic all_selected;
	logic load_cycle;
	logic advance_cycle;
	logic start_read;
	logic start_write;
	logic deselect_cycle;
	logic cont_read;
	logic cont_write;
	logic any_read;
	logic any_write;

	fsp_state_type state_q;
	fsp_state_type state_d;

	logic [ADDR_W-1:0] addr_q;
	logic [FSP_BURST_W-1:0] start_low_q;
	logic [FSP_BURST_W-1:0] cnt_q;
	logic [FSP_BURST_W-1:0] cnt_next;
	logic [ADDR_W-1:0] access_addr;

	logic wr_pend_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [LANES-1:0] wr_lane_n_q;
	logic wr_commit;

	logic drive_ok_q;
	logic drive_ok_d;

	logic [DATA_W-1:0] data_out_q;
	logic [LANES-1:0] parity_out_q;
	logic data_oe_q;
	logic parity_oe_q;

	logic [DATA_W-1:0] read_data;
	logic [LANES-1:0] read_par;
	logic bypass_hit;

	// the qualifier high makes the edge a no-op, except that output enable is still sampled
	assign suspend = clock_qualify_n;

	// two selects are active low and one active high
	assign all_selected = !chip_select_low_a && chip_select_high_b && !chip_select_low_c;

	assign load_cycle = !suspend && !advance_or_load;
	assign advance_cycle = !suspend && advance_or_load;

	assign start_read = load_cycle && all_selected && write_enable_n;
	assign start_write = load_cycle && all_selected && !write_enable_n;
	assign deselect_cycle = load_cycle && !all_selected;

	// continuation keeps the type latched at burst start, ignoring
	// the selects and write enable of this edge
	assign cont_read = advance_cycle && (state_q == FSP_ST_READ);
	assign cont_write = advance_cycle && (state_q == FSP_ST_WRITE);

	assign any_read = start_read || cont_read;
	assign any_write = start_write || cont_write;

	// ------------------------------------------------------------------
	// burst addressing
	// ------------------------------------------------------------------

	assign cnt_next = FSP_BURST_W'(cnt_q + 1'b1);

	// address used by the access that begins or continues at this edge
	always_comb begin
		if (load_cycle) begin
			access_addr = addr;
		end else begin
			access_addr = {addr_q[ADDR_W-1:FSP_BURST_W],
				fsp_burst_low(start_low_q, cnt_next, burst_order)};
		end
	end

	// address register: loaded only by a recognized load edge that starts an
	// access, so a deselect or a suspended edge leaves the burst base alone
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_q <= FSP_ADDR_RESET;
		end else if (start_read || start_write) begin
			addr_q <= addr;
		end
	end

	// starting low bits, kept apart from the counter so that interleaved
	// order can xor against them on every beat
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			start_low_q <= FSP_LOW_RESET;
		end else if (start_read || start_write) begin
			start_low_q <= addr[FSP_BURST_W-1:0];
		end
	end

	// burst counter: cleared by a load that starts an access, stepped on continuation, wraps at
	// four beats so a longer burst revisits the same four words
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= FSP_CNT_RESET;
		end else if (start_read || start_write) begin
			cnt_q <= FSP_CNT_RESET;
		end else if (cont_read || cont_write) begin
			cnt_q <= cnt_next;
		end
	end

	// ------------------------------------------------------------------
	// access state
	// ------------------------------------------------------------------

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FSP_ST_IDLE: begin
				// advance while idle has no burst to continue; the port stays
				// deselected until a fresh load arrives
				if (start_read) begin
					state_d = FSP_ST_READ;
				end else if (start_write) begin
					state_d = FSP_ST_WRITE;
				end
			end
			FSP_ST_READ, FSP_ST_WRITE: begin
				if (start_read) begin
					state_d = FSP_ST_READ;
				end else if (start_write) begin
					state_d = FSP_ST_WRITE;
				end else if (deselect_cycle) begin
					state_d = FSP_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= FSP_ST_IDLE;
		end else begin
			// a suspended edge starts nothing, so state_d equals state_q there
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------------
	// write pipeline: address and selects at one edge, data at the next
	// ------------------------------------------------------------------

	// the pending write completes on the next recognized edge, whatever
	// operation is started on that same edge
	assign wr_commit = !suspend && wr_pend_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
		end else if (!suspend) begin
			wr_pend_q <= any_write;
		end
	end

	// address and selects of the beat whose data arrives at the next edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_addr_q <= FSP_ADDR_RESET;
			wr_lane_n_q <= FSP_LANES_OFF;
		end else if (any_write) begin
			wr_addr_q <= access_addr;
			// selects are taken fresh with each beat of a burst
			wr_lane_n_q <= byte_lane_write_n;
		end
	end

	// ------------------------------------------------------------------
	// memory core
	// ------------------------------------------------------------------

	// the array lives in its own module; only its write port is clocked
	fsp_mem_if #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W),
		.LANES(LANES)
	) mem ();

	assign mem.rd_addr = access_addr;
	assign mem.wr_en = wr_commit;
	assign mem.wr_addr = wr_addr_q;
	assign mem.wr_data = data_in;
	assign mem.wr_par = parity_in;
	assign mem.wr_lane_n = wr_lane_n_q;

	fsp_core #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W),
		.LANES(LANES)
	) u_core (
		.mclk(mclk),
		.mem(mem)
	);

	// a read of the word that is being written on this same edge would see
	// the old array contents; forward the incoming lanes instead so that
	// write-then-read needs no gap
	assign bypass_hit = wr_commit && (wr_addr_q == access_addr);

	always_comb begin
		read_data = mem.rd_data;
		if (bypass_hit) begin
			read_data = fsp_merge_data(mem.rd_data, data_in, wr_lane_n_q);
		end
	end

	always_comb begin
		read_par = mem.rd_par;
		if (bypass_hit) begin
			read_par = fsp_merge_par(mem.rd_par, parity_in, wr_lane_n_q);
		end
	end

	// ------------------------------------------------------------------
	// output control
	// ------------------------------------------------------------------

	// internal permission to drive for the cycle after this edge
	always_comb begin
		if (suspend) begin
			drive_ok_d = drive_ok_q;
		end else if (start_read) begin
			// first cycle out of deselect stays quiet
			drive_ok_d = (state_q != FSP_ST_IDLE);
		end else if (cont_read) begin
			drive_ok_d = 1'b1;
		end else begin
			// write data portion, deselect, or idle advance
			drive_ok_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			drive_ok_q <= 1'b0;
		end else begin
			drive_ok_q <= drive_ok_d;
		end
	end

	// output enable is sampled at every edge, even a suspended one, so that
	// the controller can always take the drivers off the bus; it reacts one
	// edge late because the outputs are registered
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_oe_q <= 1'b0;
		end else begin
			data_oe_q <= drive_ok_d && !output_enable_n;
		end
	end

	// parity drivers follow the data drivers exactly; their own flop keeps
	// the output straight from a register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			parity_oe_q <= 1'b0;
		end else begin
			parity_oe_q <= drive_ok_d && !output_enable_n;
		end
	end

	// read word captured at the address edge: flow-through, no extra stage
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_out_q <= FSP_DATA_RESET;
		end else if (!suspend && any_read) begin
			data_out_q <= read_data;
		end
	end

	// parity word is loaded on the same edges so the pair always names one address
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			parity_out_q <= FSP_PAR_RESET;
		end else if (!suspend && any_read) begin
			parity_out_q <= read_par;
		end
	end

	assign data_out = data_out_q;
	assign parity_out = parity_out_q;
	assign data_oe = data_oe_q;
	assign parity_oe = parity_oe_q;

endmodule

// ===== sim/fsp_port_monitor.sv
module fsp_port_monitor
	import fsp_pkg::*;
#(
	parameter int DATA_W = FSP_DATA_W,
	parameter int LANES = FSP_LANES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clock_qualify_n,
	input wire logic chip_select_low_a,
	input wire logic chip_select_high_b,
	input wire logic chip_select_low_c,
	input wire logic advance_or_load,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic data_oe,
	input wire logic [LANES-1:0] parity_out,
	input wire logic parity_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire sel_ok = !chip_select_low_a && chip_select_high_b && !chip_select_low_c;
	wire rec = !clock_qualify_n;
	sequence s_rd; rec && !advance_or_load && sel_ok && write_enable_n; endsequence
	sequence s_wr; rec && !advance_or_load && sel_ok && !write_enable_n; endsequence
	sequence s_desel; rec && !advance_or_load && !sel_ok; endsequence
	sequence s_adv; rec && advance_or_load; endsequence
	property p_oe_pair; data_oe == parity_oe; endproperty
	property p_oe_mask; output_enable_n |=> !data_oe; endproperty
	property p_hold; clock_qualify_n |=> $stable(data_out) && $stable(parity_out); endproperty
	property p_wr_off; s_wr |=> !data_oe; endproperty
	property p_desel_off; s_desel |=> !data_oe && !parity_oe; endproperty
	// the first read out of deselect never drives, whatever output enable says
	property p_first_rd; s_desel ##1 s_rd |=> !data_oe; endproperty
	property p_b2b_rd; s_rd ##1 (s_rd ##0 !output_enable_n) |=> data_oe; endproperty
	property p_burst_rd; s_rd ##1 (s_adv ##0 !output_enable_n) |=> data_oe && parity_oe; endproperty
	property p_wr_burst; s_wr ##1 s_adv |=> !data_oe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
	a_oe_mask: assert property (p_oe_mask) else $error("driving with oe high");
	a_hold: assert property (p_hold) else $error("output moved on suspend");
	a_wr_off: assert property (p_wr_off) else $error("driving in write");
	a_desel_off: assert property (p_desel_off) else $error("driving deselected");
	a_first_rd: assert property (p_first_rd) else $error("first read drove");
	a_b2b_rd: assert property (p_b2b_rd) else $error("second read not driven");
	a_burst_rd: assert property (p_burst_rd) else $error("burst read not driven");
	a_wr_burst: assert property (p_wr_burst) else $error("burst write drove");
endmodule

bind fsp_port fsp_port_monitor #(.DATA_W(DATA_W), .LANES(LANES)) MON (
	.mclk(mclk), .rst(rst), .clock_qualify_n(clock_qualify_n),
	.chip_select_low_a(chip_select_low_a), .chip_select_high_b(chip_select_high_b),
	.chip_select_low_c(chip_select_low_c), .advance_or_load(advance_or_load),
	.write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
	.data_out(data_out), .data_oe(data_oe), .parity_out(parity_out), .parity_oe(parity_oe));

// ===== sim/fsp_ctl_model.sv
module fsp_ctl_model
	import fsp_pkg::*;
(
	input wire logic mclk,
	input wire logic drive_en,
	input wire logic [FSP_DATA_W+FSP_LANES-1:0] value,
	output logic [FSP_DATA_W-1:0] data_in,
	output logic [FSP_LANES-1:0] parity_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [FSP_DATA_W+FSP_LANES-1:0] last_q;
	always_ff @(posedge mclk) begin
		if (drive_en) begin
			last_q <= value;
		end
	end
	// released lines show the inverse so a late sample cannot match stale data
	assign {parity_in, data_in} = drive_en ? value : ~last_q;
endmodule

// ===== sim/tb_flow_through_burst_sram_port.sv
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end \
end
module tb_flow_through_burst_sram_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst = 1'b1, qn = 1'b1, cs = 1'b0, adv = 1'b0;
	logic we_n = 1'b1, oe_n = 1'b1, bo = 1'b0, pd = 1'b0;
	logic [3:0] ln = 4'hF;
	logic [16:0] ad = 17'h00000;
	logic [35:0] pv = 36'h000000000;
	logic [35:0] rm [0:15];
	wire [31:0] din, dout;
	wire [3:0] pin, pout;
	wire doe, poe;
	int err_count = 0, comparisons = 0;
	initial forever #25 mclk = ~mclk;
	fsp_port DUT (.mclk(mclk), .rst(rst), .clock_qualify_n(qn), .chip_select_low_a(!cs),
		.chip_select_high_b(cs), .chip_select_low_c(!cs), .advance_or_load(adv),
		.write_enable_n(we_n), .byte_lane_write_n(ln), .addr(ad), .output_enable_n(oe_n),
		.burst_order(bo), .data_in(din), .data_out(dout), .data_oe(doe),
		.parity_in(pin), .parity_out(pout), .parity_oe(poe));
	fsp_ctl_model PM (.mclk(mclk), .drive_en(pd), .value(pv), .data_in(din), .parity_in(pin));
	task cyc(input logic q, c, v, w, input logic [3:0] l, input logic [16:0] a,
		input logic o, d, input logic [35:0] x);
		@(posedge mclk);
		qn <= q;
		cs <= c;
		adv <= v;
		we_n <= w;
		ln <= l;
		ad <= a;
		oe_n <= o;
		pd <= d;
		pv <= x;
	endtask
	function logic [16:0] baddr(input logic [16:0] a, input logic [1:0] k);
		baddr = a;
		baddr[1:0] = bo ? (a[1:0] ^ k) : (a[1:0] + k);
	endfunction
	task chkrd(input logic [16:0] t, input logic e);
		`CHK("rd_data", rm[t[3:0]][31:0], dout)
		`CHK("rd_par", rm[t[3:0]][35:32], pout)
		`CHK("rd_oe", e, doe)
	endtask
	task t_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (8) @(posedge mclk);
		#1 `CHK("rst_oe", 1'b0, doe)
		`CHK("rst_poe", 1'b0, poe)
		`CHK("rst_data", 32'h00000000, dout)
		@(posedge mclk);
		rst <= 1'b0;
	endtask
	task t_write(input logic [16:0] a, input logic o);
		logic [16:0] t;
		@(posedge mclk);
		bo <= o;
		pd <= 1'b0;
		// output enable held low: the port must mask it for the whole write
		cyc(0, 1, 0, 0, 4'h0, a, 0, 0, '0);
		for (int k = 0; k < 4; k++) begin
			t = baddr(a, k[1:0]);
			rm[t[3:0]] = 36'h5C0DE0000 + 36'(t) * 36'h11 + 36'(k);
			// selects dropped and address scrambled on advance edges: both must be ignored
			cyc(0, 0, k < 3, 1, k < 3 ? 4'h0 : 4'hF, 17'h1FFFF, 0, 1, rm[t[3:0]]);
			#1 `CHK("wr_oe", 1'b0, doe)
		end
	endtask
	task t_read(input logic [16:0] a, input logic o, input logic sus);
		logic [16:0] t;
		@(posedge mclk);
		bo <= o;
		pd <= 1'b0;
		cyc(0, 1, 0, 1, 4'hF, a, 0, 0, '0);
		for (int k = 0; k < 4; k++) begin
			t = baddr(a, k[1:0]);
			if (sus && k == 1) begin
				// suspended edge carries a write load that must not take effect
				cyc(1, 1, 0, 0, 4'h0, 17'h00000, 0, 0, '0);
				#1 chkrd(t, 1'b1);
			end
			cyc(0, 0, k < 3, 1, 4'hF, 17'h1FFFF, 0, 0, '0);
			#1 chkrd(t, k > 0);
		end
		cyc(0, 0, 0, 1, 4'hF, 17'h1FFFF, 0, 0, '0);
		#1 `CHK("desel_oe", 1'b0, doe)
	endtask
	task t_lanes;
		logic [3:0] l;
		logic [35:0] x;
		for (int i = 0; i < 2; i++) begin
			l = i ? 4'hF : 4'h5;
			x = 36'h987654321 ^ 36'(i);
			cyc(0, 1, 0, 0, l, 17'h00009, 1, 0, '0);
			cyc(0, 1, 0, 1, 4'hF, 17'h00009, 0, 1, x);
			for (int n = 0; n < 4; n++) begin
				if (!l[n]) begin
					rm[9][8*n +: 8] = x[8*n +: 8];
					rm[9][32+n] = x[32+n];
				end
			end
			// second pass reads again with output enable high: drivers must stay off
			cyc(0, 1, 0, 1, 4'hF, 17'h00009, i[0], 0, '0);
			#1 chkrd(17'h00009, 1'b1);
			cyc(0, 0, 0, 1, 4'hF, 17'h00009, 0, 0, '0);
			#1 chkrd(17'h00009, !i[0]);
			cyc(0, 0, 0, 1, 4'hF, 17'h00009, 1, 0, '0);
			#1 `CHK("lane_oe", 1'b0, doe)
		end
	endtask
	task complete_run;
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		t_reset();
		t_write(17'h00005, 1'b0);
		t_read(17'h00006, 1'b1, 1'b1);
		t_write(17'h0000B, 1'b1);
		t_read(17'h00009, 1'b0, 1'b0);
		t_lanes();
		t_reset();
		t_read(17'h00005, 1'b0, 1'b0);
		complete_run();
	end
endmodule
